// *** inc/cfg_fwd_pkg.sv ***
package cfg_fwd_pkg;

  // bus commands on the command/byte-enable lines
  localparam logic [3:0] CMD_SPECIAL = 4'h1;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;

  // address format codes in ad[1:0]
  localparam logic [1:0] FMT_TYPE0 = 2'h0;
  localparam logic [1:0] FMT_TYPE1 = 2'h1;

  // field positions of a configuration address
  localparam int REG_LSB = 2;
  localparam int REG_MSB = 7;
  localparam int FUNC_LSB = 8;
  localparam int FUNC_MSB = 10;
  localparam int DEV_LSB = 11;
  localparam int DEV_MSB = 15;
  localparam int BUS_LSB = 16;
  localparam int BUS_MSB = 23;
  localparam int IDSEL_LSB = 16;
  localparam int IDSEL_BITS = 16;

  localparam logic [4:0] DEV_SPECIAL = 5'h1f;
  localparam logic [2:0] FUNC_SPECIAL = 3'h7;
  localparam logic [5:0] REG_ZERO = 6'h00;
  localparam logic [3:0] BE_ALL = 4'hf;

  // reset values
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [5:0] REG_RST = 6'h00;
  localparam logic [3:0] NIBBLE_RST = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_OWN = 3'h2,
    ST_RETRY = 3'h4
  } fwd_state_t;

endpackage

// *** verilog/cfg_addr_translator.sv ***
// turns a type 1 address into its type 0 form for the secondary bus
module cfg_addr_translator (
  input wire logic [31:0] type1_addr_i,
  output logic [31:0] type0_addr_o,
  output logic special_o
);

  logic [4:0] dev;
  logic [5:0] regn;
  logic [cfg_fwd_pkg::IDSEL_BITS-1:0] idsel;

  assign dev = type1_addr_i[cfg_fwd_pkg::DEV_MSB:cfg_fwd_pkg::DEV_LSB];
  assign regn = type1_addr_i[cfg_fwd_pkg::REG_MSB:cfg_fwd_pkg::REG_LSB];

  // devices above 0fh leave every select line low
  for (genvar i = 0; i < cfg_fwd_pkg::IDSEL_BITS; i++) begin : g_idsel
    assign idsel[i] = !dev[4] && (dev[3:0] == 4'(i));
  end

  // function and register number pass through, device field zeroed
  assign type0_addr_o = {idsel, 5'h00,
    type1_addr_i[cfg_fwd_pkg::FUNC_MSB:cfg_fwd_pkg::REG_LSB],
    cfg_fwd_pkg::FMT_TYPE0};
  assign special_o = (dev == cfg_fwd_pkg::DEV_SPECIAL) &&
    (regn != cfg_fwd_pkg::REG_ZERO);

endmodule // cfg_addr_translator

// *** verilog/pci_config_cycle_forwarder.sv ***
module pci_config_cycle_forwarder (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic p_addr_valid_i,
  input wire logic [31:0] p_ad_i,
  input wire logic [3:0] primary_cmd_byte_enables_i,
  input wire logic primary_id_select_i,
  input wire logic p_frame_i,
  input wire logic p_irdy_i,
  output logic primary_device_select_n_o,
  output logic p_trdy_n_o,
  output logic p_stop_n_o,
  output logic [31:0] p_rdata_o,
  input wire logic s_addr_valid_i,
  input wire logic [31:0] s_ad_i,
  input wire logic [3:0] s_cmd_i,
  output logic s_device_select_n_o,
  output logic s_stop_n_o,
  input wire logic [7:0] primary_bus_num_i,
  input wire logic [7:0] sec_bus_num_i,
  input wire logic [7:0] sub_bus_num_i,
  output logic cfg_req_o,
  output logic cfg_write_o,
  output logic [5:0] cfg_reg_o,
  output logic [3:0] cfg_be_o,
  output logic [31:0] cfg_wdata_o,
  input wire logic [31:0] cfg_rdata_i,
  output logic fwd_valid_o,
  output logic fwd_upstream_o,
  output logic [31:0] fwd_addr_o,
  output logic [3:0] fwd_cmd_o
);

  typedef struct packed {
    cfg_fwd_pkg::fwd_state_t state;
    logic p_devsel_n;
    logic p_trdy_n;
    logic p_stop_n;
    logic [31:0] p_rdata;
    logic s_devsel_n;
    logic s_stop_n;
    logic cfg_req;
    logic cfg_write;
    logic [5:0] cfg_reg;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata;
    logic fwd_valid;
    logic fwd_upstream;
    logic [31:0] fwd_addr;
    logic [3:0] fwd_cmd;
  } fwd_regs_t;

  fwd_regs_t cur;
  fwd_regs_t next_cur;

  logic [3:0] p_cmd;
  logic [7:0] p_bus;
  logic [7:0] s_bus;
  logic p_is_cfg;
  logic p_type0;
  logic p_type1;
  logic s_type1;
  logic own_hit;
  logic conv_hit;
  logic down_hit;
  logic up_hit;
  logic conv_special;
  logic idle;
  logic [31:0] conv_addr;

  assign p_cmd = primary_cmd_byte_enables_i;
  assign p_bus = p_ad_i[cfg_fwd_pkg::BUS_MSB:cfg_fwd_pkg::BUS_LSB];
  assign s_bus = s_ad_i[cfg_fwd_pkg::BUS_MSB:cfg_fwd_pkg::BUS_LSB];
  assign p_is_cfg = (p_cmd == cfg_fwd_pkg::CMD_CFG_RD) ||
    (p_cmd == cfg_fwd_pkg::CMD_CFG_WR);
  assign p_type0 = p_ad_i[1:0] == cfg_fwd_pkg::FMT_TYPE0;
  assign p_type1 = p_ad_i[1:0] == cfg_fwd_pkg::FMT_TYPE1;
  assign s_type1 = s_ad_i[1:0] == cfg_fwd_pkg::FMT_TYPE1;
  assign idle = cur.state == cfg_fwd_pkg::ST_IDLE;

  assign own_hit = p_addr_valid_i && p_is_cfg && p_type0 &&
    primary_id_select_i;
  assign conv_hit = p_addr_valid_i && p_is_cfg && p_type1 &&
    (p_bus == sec_bus_num_i);
  assign down_hit = p_addr_valid_i && p_is_cfg && p_type1 &&
    (p_bus > sec_bus_num_i) && (p_bus <= sub_bus_num_i);
  // type 0 on the secondary side never qualifies here
  assign up_hit = s_addr_valid_i && (s_cmd_i == cfg_fwd_pkg::CMD_CFG_WR) &&
    s_type1 && ((s_bus < sec_bus_num_i) || (s_bus > sub_bus_num_i)) &&
    (s_ad_i[cfg_fwd_pkg::DEV_MSB:cfg_fwd_pkg::DEV_LSB] ==
      cfg_fwd_pkg::DEV_SPECIAL) &&
    (s_ad_i[cfg_fwd_pkg::FUNC_MSB:cfg_fwd_pkg::FUNC_LSB] ==
      cfg_fwd_pkg::FUNC_SPECIAL);

  cfg_addr_translator u_xlate (
    .type1_addr_i(p_ad_i),
    .type0_addr_o(conv_addr),
    .special_o(conv_special)
  );

  always_comb begin
    next_cur = cur;
    next_cur.p_devsel_n = 1'b1;
    next_cur.p_trdy_n = 1'b1;
    next_cur.p_stop_n = 1'b1;
    next_cur.s_devsel_n = 1'b1;
    next_cur.s_stop_n = 1'b1;
    next_cur.cfg_req = 1'b0;
    next_cur.fwd_valid = 1'b0;
    case (cur.state)
      cfg_fwd_pkg::ST_IDLE: begin
        // primary wins a same-cycle tie; the secondary attempt gets neither devsel nor stop
        if (own_hit) begin
          next_cur.state = cfg_fwd_pkg::ST_OWN;
          next_cur.p_devsel_n = 1'b0;
          next_cur.cfg_write = p_cmd == cfg_fwd_pkg::CMD_CFG_WR;
          next_cur.cfg_reg =
            p_ad_i[cfg_fwd_pkg::REG_MSB:cfg_fwd_pkg::REG_LSB];
        end else if (conv_hit || down_hit) begin
          // delayed: register the request, tell the initiator to retry
          next_cur.state = cfg_fwd_pkg::ST_RETRY;
          next_cur.p_devsel_n = 1'b0;
          next_cur.p_stop_n = 1'b0;
          next_cur.fwd_valid = 1'b1;
          next_cur.fwd_upstream = 1'b0;
          if (conv_hit && conv_special &&
              (p_cmd == cfg_fwd_pkg::CMD_CFG_WR)) begin
            next_cur.fwd_addr = p_ad_i;
            next_cur.fwd_cmd = cfg_fwd_pkg::CMD_SPECIAL;
          end else if (conv_hit) begin
            next_cur.fwd_addr = conv_addr;
            next_cur.fwd_cmd = p_cmd;
          end else begin
            next_cur.fwd_addr = p_ad_i;
            next_cur.fwd_cmd = p_cmd;
          end
        end else if (up_hit) begin
          next_cur.state = cfg_fwd_pkg::ST_RETRY;
          next_cur.s_devsel_n = 1'b0;
          next_cur.s_stop_n = 1'b0;
          next_cur.fwd_valid = 1'b1;
          next_cur.fwd_upstream = 1'b1;
          next_cur.fwd_addr = s_ad_i;
          next_cur.fwd_cmd = (s_bus == primary_bus_num_i) ?
            cfg_fwd_pkg::CMD_SPECIAL : s_cmd_i;
        end
      end
      cfg_fwd_pkg::ST_OWN: begin
        next_cur.p_devsel_n = 1'b0;
        if (p_irdy_i) begin
          // no buffer involved, so the transfer never waits or retries
          next_cur.state = cfg_fwd_pkg::ST_IDLE;
          next_cur.p_trdy_n = 1'b0;
          next_cur.p_stop_n = !p_frame_i;
          next_cur.cfg_req = 1'b1;
          next_cur.cfg_wdata = p_ad_i;
          next_cur.cfg_be = cur.cfg_write ? p_cmd : cfg_fwd_pkg::BE_ALL;
          next_cur.p_rdata = cfg_rdata_i;
        end
      end
      cfg_fwd_pkg::ST_RETRY: begin
        next_cur.state = cfg_fwd_pkg::ST_IDLE;
      end
      default: begin
        next_cur.state = cfg_fwd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cur.state <= cfg_fwd_pkg::ST_IDLE;
      cur.p_devsel_n <= 1'b1;
      cur.p_trdy_n <= 1'b1;
      cur.p_stop_n <= 1'b1;
      cur.p_rdata <= cfg_fwd_pkg::DATA_RST;
      cur.s_devsel_n <= 1'b1;
      cur.s_stop_n <= 1'b1;
      cur.cfg_req <= 1'b0;
      cur.cfg_write <= 1'b0;
      cur.cfg_reg <= cfg_fwd_pkg::REG_RST;
      cur.cfg_be <= cfg_fwd_pkg::NIBBLE_RST;
      cur.cfg_wdata <= cfg_fwd_pkg::DATA_RST;
      cur.fwd_valid <= 1'b0;
      cur.fwd_upstream <= 1'b0;
      cur.fwd_addr <= cfg_fwd_pkg::DATA_RST;
      cur.fwd_cmd <= cfg_fwd_pkg::NIBBLE_RST;
    end else begin
      cur <= next_cur;
    end
  end

  assign primary_device_select_n_o = cur.p_devsel_n;
  assign p_trdy_n_o = cur.p_trdy_n;
  assign p_stop_n_o = cur.p_stop_n;
  assign p_rdata_o = cur.p_rdata;
  assign s_device_select_n_o = cur.s_devsel_n;
  assign s_stop_n_o = cur.s_stop_n;
  assign cfg_req_o = cur.cfg_req;
  assign cfg_write_o = cur.cfg_write;
  assign cfg_reg_o = cur.cfg_reg;
  assign cfg_be_o = cur.cfg_be;
  assign cfg_wdata_o = cur.cfg_wdata;
  assign fwd_valid_o = cur.fwd_valid;
  assign fwd_upstream_o = cur.fwd_upstream;
  assign fwd_addr_o = cur.fwd_addr;
  assign fwd_cmd_o = cur.fwd_cmd;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_own_claim: assert property (idle && own_hit |=>
    !primary_device_select_n_o && cur.state == cfg_fwd_pkg::ST_OWN)
    else $error("own type 0 access not claimed");
  a_sec_type0_ignored: assert property (
    s_addr_valid_i && s_ad_i[1:0] == cfg_fwd_pkg::FMT_TYPE0 |=>
    s_device_select_n_o)
    else $error("secondary type 0 access claimed");
  a_single_dword: assert property (
    cur.state == cfg_fwd_pkg::ST_OWN && p_irdy_i && p_frame_i |=>
    !p_trdy_n_o && !p_stop_n_o ##1 p_trdy_n_o && p_stop_n_o)
    else $error("no disconnect with first own transfer");
  a_read_all_bytes: assert property (
    cfg_req_o && !cfg_write_o |-> cfg_be_o == cfg_fwd_pkg::BE_ALL)
    else $error("own read did not take all bytes");
  a_own_no_retry: assert property (
    cur.state == cfg_fwd_pkg::ST_OWN && p_irdy_i |=>
    !p_trdy_n_o && cfg_req_o && $past(cfg_rdata_i) == p_rdata_o)
    else $error("own access did not complete at once");
  a_conv_format: assert property (
    idle && conv_hit && !own_hit && !conv_special |=>
    fwd_valid_o && fwd_addr_o[1:0] == cfg_fwd_pkg::FMT_TYPE0 &&
    fwd_addr_o[15:11] == 5'h00 && fwd_addr_o[10:2] == $past(p_ad_i[10:2]))
    else $error("type 1 to type 0 address wrong");
  a_idsel_onehot: assert property (
    idle && conv_hit && !own_hit && !p_ad_i[15] |=>
    fwd_addr_o[31:16] == (16'h0001 << $past(p_ad_i[14:11])))
    else $error("select line pattern wrong");
  a_upstream_type1: assert property (
    fwd_valid_o && fwd_upstream_o |-> fwd_addr_o[1:0] ==
    cfg_fwd_pkg::FMT_TYPE1)
    else $error("type 0 produced upstream");
  a_fwd_retried: assert property (
    fwd_valid_o |-> (fwd_upstream_o ? !s_stop_n_o : !p_stop_n_o) &&
    p_trdy_n_o)
    else $error("forwarded access not retried");
  a_up_forward: assert property (
    idle && up_hit && !p_addr_valid_i |=> fwd_valid_o && fwd_upstream_o)
    else $error("upstream write not forwarded");
  a_no_stray_claim: assert property (
    idle && p_addr_valid_i && !own_hit && !conv_hit && !down_hit |=>
    primary_device_select_n_o)
    else $error("unqualified access claimed");

  c_own_read: cover property (idle && own_hit && !p_cmd[0]
    ##[1:8] !p_trdy_n_o);
  c_own_disconnect: cover property (!p_trdy_n_o && !p_stop_n_o);
  c_conversion: cover property (fwd_valid_o && !fwd_upstream_o &&
    fwd_addr_o[1:0] == cfg_fwd_pkg::FMT_TYPE0);
  c_special: cover property (fwd_valid_o &&
    fwd_cmd_o == cfg_fwd_pkg::CMD_SPECIAL);

endmodule // pci_config_cycle_forwarder

// *** dv/pci_initiator_model.sv ***
module pci_initiator_model (
  input wire logic clk_i,
  input wire logic devsel_n_i,
  input wire logic trdy_n_i,
  input wire logic stop_n_i,
  output logic addr_valid_o,
  output logic [31:0] ad_o,
  output logic [3:0] cbe_o,
  output logic id_o,
  output logic frame_o,
  output logic irdy_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    addr_valid_o = 1'b0;
    ad_o = 32'h0;
    cbe_o = 4'h0;
    id_o = 1'b0;
    frame_o = 1'b0;
    irdy_o = 1'b0;
  end

  // seen: devsel and stop after claim, then trdy and stop of data phase
  task automatic cycle(input logic [31:0] a, input logic [3:0] c,
      input logic id, input logic [3:0] be, input logic [31:0] wd,
      input logic more, input int lag, output logic [3:0] seen);
    @(posedge clk_i) #1;
    addr_valid_o = 1'b1;
    ad_o = a;
    cbe_o = c;
    id_o = id;
    @(posedge clk_i) #1;
    addr_valid_o = 1'b0;
    ad_o = ~a;
    id_o = 1'b0;
    seen = {devsel_n_i, stop_n_i, 2'h3};
    if (!devsel_n_i && stop_n_i) begin
      // slow initiator: wait states before ready
      repeat (lag) @(posedge clk_i) #1;
      irdy_o = 1'b1;
      ad_o = wd;
      cbe_o = be;
      frame_o = more;
      @(posedge clk_i) #1;
      seen[1:0] = {trdy_n_i, stop_n_i};
      irdy_o = 1'b0;
      frame_o = 1'b0;
      ad_o = ~wd;
    end
    @(posedge clk_i) #1;
  endtask
endmodule // pci_initiator_model

// *** dv/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sav = 1'b0;
  logic [31:0] sad = 32'h0;
  logic [3:0] scmd = 4'h0;
  logic [7:0] pbus = 8'h00;
  logic [7:0] sbus = 8'h12;
  logic [7:0] subus = 8'h17;
  wire logic pav, pid, pfr, pirdy, dsel, trdy, stp, sdev, sstp;
  wire logic creq, cwr, fv, fup;
  wire logic [31:0] pad, rdat, cwd, crd, fad;
  wire logic [3:0] pcbe, cbe, fcmd;
  wire logic [5:0] creg;
  int bad_count = 0;
  int n_checks = 0;
  int seed = 4333;
  int cyc = 0;
  logic [42:0] own_q[$];
  logic [36:0] fwd_q[$];
  logic [31:0] a, r;
  logic [7:0] b;
  logic [3:0] c;

  always #50 clk = ~clk;
  // register space behind the own-config port
  assign crd = {creg, ~creg, 20'hbeef5};

  pci_config_cycle_forwarder pci_config_cycle_forwarder_i (
    .ref_clk_i(clk), .sys_rst_i(rst), .p_addr_valid_i(pav),
    .p_ad_i(pad), .primary_cmd_byte_enables_i(pcbe),
    .primary_id_select_i(pid), .p_frame_i(pfr), .p_irdy_i(pirdy),
    .primary_device_select_n_o(dsel), .p_trdy_n_o(trdy),
    .p_stop_n_o(stp), .p_rdata_o(rdat), .s_addr_valid_i(sav),
    .s_ad_i(sad), .s_cmd_i(scmd), .s_device_select_n_o(sdev),
    .s_stop_n_o(sstp), .primary_bus_num_i(pbus), .sec_bus_num_i(sbus),
    .sub_bus_num_i(subus), .cfg_req_o(creq), .cfg_write_o(cwr),
    .cfg_reg_o(creg), .cfg_be_o(cbe), .cfg_wdata_o(cwd),
    .cfg_rdata_i(crd), .fwd_valid_o(fv), .fwd_upstream_o(fup),
    .fwd_addr_o(fad), .fwd_cmd_o(fcmd));

  pci_initiator_model pci_initiator_model_i (
    .clk_i(clk), .devsel_n_i(dsel), .trdy_n_i(trdy), .stop_n_i(stp),
    .addr_valid_o(pav), .ad_o(pad), .cbe_o(pcbe), .id_o(pid),
    .frame_o(pfr), .irdy_o(pirdy));

  task automatic fail(input logic [63:0] g, input logic [63:0] e);
    bad_count++;
    $display("[ERR] %0t got %h exp %h", $time, g, e);
  endtask
  task automatic chk_own(input logic [42:0] g, input logic [42:0] e);
    n_checks++;
    if (g !== e) fail(g, e);
  endtask
  task automatic chk_fwd(input logic [36:0] g, input logic [36:0] e);
    n_checks++;
    if (g !== e) fail(g, e);
  endtask
  task automatic chk_hs(input logic [3:0] g, input logic [3:0] e);
    n_checks++;
    if (g !== e) fail(g, e);
  endtask

  task automatic results();
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // expected target-bus address and command of a converted access
  function automatic logic [36:0] conv(input logic [31:0] x,
      input logic [3:0] k);
    logic [15:0] sel;
    sel = x[15] ? 16'h0 : 16'h1 << x[14:11];
    if (k == cfg_fwd_pkg::CMD_CFG_WR && x[15:11] == 5'h1f && x[7:2] != 0)
      return {1'b0, x, cfg_fwd_pkg::CMD_SPECIAL};
    return {1'b0, sel, 5'h0, x[10:2], 2'h0, k};
  endfunction

  // k: 0 unclaimed, 1 own space, 2 forwarded with note fn
  task automatic pri(input logic [31:0] x, input logic [3:0] k2,
      input logic id, input int k, input logic [36:0] fn);
    logic [3:0] s, be;
    logic [31:0] wd;
    logic more;
    int lag;
    be = $random(seed);
    wd = $random(seed);
    more = $random(seed);
    lag = {$random(seed)} % 3;
    if (k == 1)
      own_q.push_back({k2[0], x[7:2], k2[0] ? be : 4'hf,
        k2[0] ? wd : {x[7:2], ~x[7:2], 20'hbeef5}});
    if (k == 2)
      fwd_q.push_back(fn);
    pci_initiator_model_i.cycle(x, k2, id, be, wd, more, lag, s);
    chk_hs(s, k == 0 ? 4'hf : k == 1 ? {3'h2, ~more} : 4'h3);
  endtask

  task automatic sec(input logic [31:0] x, input logic [3:0] k2,
      input logic [36:0] fn, input logic k);
    if (k)
      fwd_q.push_back(fn);
    @(posedge clk) #1;
    sav = 1'b1;
    sad = x;
    scmd = k2;
    @(posedge clk) #1;
    sav = 1'b0;
    sad = ~x;
    chk_hs({2'h3, sdev, sstp}, k ? 4'hc : 4'hf);
    @(posedge clk) #1;
  endtask

  always @(negedge clk) begin
    if (creq)
      chk_own({cwr, creg, cbe, cwr ? cwd : rdat},
        own_q.size() ? own_q.pop_front() : 43'hx);
    if (fv)
      chk_fwd({fup, fad, fcmd},
        fwd_q.size() ? fwd_q.pop_front() : 37'hx);
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      c = i[0] ? cfg_fwd_pkg::CMD_CFG_WR : cfg_fwd_pkg::CMD_CFG_RD;
      pri({r[31:2], 2'h0}, c, 1'b1, 1, 37'h0);
    end
    pri({r[31:2], 2'h0}, cfg_fwd_pkg::CMD_CFG_RD, 1'b0, 0, 37'h0);
    pri({r[31:2], 2'h0}, 4'h6, 1'b1, 0, 37'h0);
    sec({r[31:2], 2'h0}, cfg_fwd_pkg::CMD_CFG_WR, 37'h0, 1'b0);
    for (int k = 0; k < 34; k++) begin
      r = $random(seed);
      c = k[0] ? cfg_fwd_pkg::CMD_CFG_WR : cfg_fwd_pkg::CMD_CFG_RD;
      a = {8'h0, sbus, k > 31 ? 5'h1f : k[4:0], r[10:8],
        k > 32 ? 6'h0 : r[7:2] | 6'h1, 2'h1};
      pri(a, c, r[0], 2, conv(a, c));
    end
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      b = k == 0 ? 8'h13 : k == 1 ? 8'h17 : k == 2 ? 8'h18 : 8'h11;
      a = {8'h0, b, r[15:2], 2'h1};
      c = r[0] ? cfg_fwd_pkg::CMD_CFG_WR : cfg_fwd_pkg::CMD_CFG_RD;
      pri(a, c, 1'b0, k < 2 ? 2 : 0, {1'b0, a, c});
    end
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      b = k == 0 ? pbus : k == 1 ? 8'h30 : 8'h12;
      a = {8'h0, b, 5'h1f, 3'h7, r[7:2], 2'h1};
      c = k == 3 ? cfg_fwd_pkg::CMD_CFG_RD : cfg_fwd_pkg::CMD_CFG_WR;
      sec(a, c, {1'b1, a, k == 0 ? cfg_fwd_pkg::CMD_SPECIAL : c},
        k < 2);
    end
    chk_hs({own_q.size() == 0, fwd_q.size() == 0, 2'h3}, 4'hf);
    results();
  end
endmodule // tb
